//--- common/timer_pkg.sv
// Constants and types shared by the dual timer/counter block.
// Assumes a single 25 MHz system clock and plain-port control.
package timer_pkg;

  localparam int CNT_W          = 16;
  localparam int PRESCALE_W     = 5;
  localparam logic [4:0] PRESCALE_MAX = 5'h10;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] LFSR_SEED = 16'hACE1;
  localparam logic [16:0] PRESCALE_RESET = 17'h00000;

  // Mode select encoding.
  localparam logic [2:0] MODE_TIMER   = 3'h0;
  localparam logic [2:0] MODE_COUNTER = 3'h1;
  localparam logic [2:0] MODE_PWM     = 3'h2;
  localparam logic [2:0] MODE_CAPTURE = 3'h3;
  localparam logic [2:0] MODE_DELTA   = 3'h4;

  // Edge select for event counting: bit 0 rising, bit 1 falling.
  localparam int EDGE_RISE_BIT = 0;
  localparam int EDGE_FALL_BIT = 1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_DONE = 3'b100
  } run_state_t;

endpackage

//--- src/pin_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Pin and result
  input  wire logic pin,
  output logic      level
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A change counts only once the second and third stages agree.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      level <= 1'b0;
    end else if (s2 == s3) begin
      level <= s3;
    end
  end
endmodule
`default_nettype wire

//--- src/timer_unit.sv
// One general-purpose timer/counter unit: prescaler, 16-bit counter,
// rise/fall compare-capture registers, PWM, capture, event and delta-sigma.
// Assumes control ports are quasi-static, driven from logic on clk; the
// system places two independent instances of this module.
`timescale 1ns/1ps
`default_nettype none
module timer_unit
  import timer_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // Control
  input  wire logic                  start,
  input  wire logic                  stop,
  input  wire logic [2:0]            mode,
  input  wire logic                  single_shot,
  input  wire logic                  gate_enable,
  input  wire logic [1:0]            edge_select,
  input  wire logic                  pulse_separated_mode,
  input  wire logic [PRESCALE_W-1:0] prescale,
  input  wire logic                  rise_irq_enable,
  input  wire logic                  fall_irq_enable,
  input  wire logic                  output_enable,
  input  wire logic                  capture_read,
  // Compare values from software
  input  wire logic                  rise_write,
  input  wire logic                  fall_write,
  input  wire logic [CNT_W-1:0]      write_data,
  // Pins
  input  wire logic                  clock_gate_input,
  input  wire logic                  capture_input,
  output logic                       timer_output,
  output logic                       timer_output_oe,
  // Status
  output logic [CNT_W-1:0]           count,
  output logic [CNT_W-1:0]           rise_value,
  output logic [CNT_W-1:0]           fall_value,
  output logic                       running,
  output logic                       irq
);
  ////////////////////////////////////////////////////////////////////////////
  logic             gate_level;
  logic             cap_level;
  logic             gate_prev;
  logic             cap_prev;
  logic [16:0]      prediv;
  logic             tick;
  logic             event_tick;
  logic             step;
  logic             out_level;
  logic             phase;
  logic [CNT_W-1:0] lfsr;
  logic [CNT_W-1:0] key;
  logic             rise_hit;
  logic             fall_hit;
  run_state_t       state;

  pin_sync u_gate_sync (
    .clk    (clk),
    .resetn (resetn),
    .pin    (clock_gate_input),
    .level  (gate_level)
  );

  pin_sync u_cap_sync (
    .clk    (clk),
    .resetn (resetn),
    .pin    (capture_input),
    .level  (cap_level)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gate_prev <= 1'b0;
      cap_prev  <= 1'b0;
    end else begin
      gate_prev <= gate_level;
      cap_prev  <= cap_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler: a free divider whose low bits all set mark the tick.
  // Settings above the maximum are clamped rather than wrapped.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prediv <= PRESCALE_RESET;
    end else if (start) begin
      prediv <= PRESCALE_RESET;
    end else begin
      prediv <= prediv + 17'h00001;
    end
  end

  always_comb begin
    logic [4:0]  ps;
    logic [16:0] mask;
    ps   = (prescale > PRESCALE_MAX) ? PRESCALE_MAX : prescale;
    mask = (17'h00001 << ps) - 17'h00001;
    tick = ((prediv & mask) == mask);
  end

  always_comb begin
    logic rise_e;
    logic fall_e;
    rise_e     = gate_level & ~gate_prev;
    fall_e     = ~gate_level & gate_prev;
    event_tick = (rise_e & edge_select[EDGE_RISE_BIT])
               | (fall_e & edge_select[EDGE_FALL_BIT]);
  end

  always_comb begin
    step = 1'b0;
    if (state == ST_RUN) begin
      if (mode == MODE_COUNTER) begin
        step = event_tick;
      end else if (mode == MODE_DELTA) begin
        step = 1'b1;
      end else begin
        step = tick & ~(gate_enable & gate_level);
      end
    end
  end

  assign rise_hit = step && (count == rise_value);
  assign fall_hit = step && (count == fall_value);

  ////////////////////////////////////////////////////////////////////////////
  // Run control.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (stop) begin
            state <= ST_IDLE;
          end else if (mode == MODE_CAPTURE && capture_read) begin
            state <= ST_DONE;
          end else if (single_shot && fall_hit
                       && mode != MODE_CAPTURE && mode != MODE_DELTA) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (start) begin
            state <= ST_RUN;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      running <= 1'b0;
    end else begin
      running <= (state == ST_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= CNT_RESET;
    end else if (start) begin
      count <= CNT_RESET;
    end else if (step) begin
      if (mode == MODE_DELTA && pulse_separated_mode && !phase) begin
        count <= count;
      end else if (fall_hit && !single_shot
                   && (mode == MODE_PWM || mode == MODE_TIMER
                       || mode == MODE_COUNTER)) begin
        count <= CNT_RESET;
      end else begin
        count <= count + 16'h0001;
      end
    end
  end

  // PULSE_SEPARATED_MODE phase: every other period is a forced-low slot.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase <= 1'b0;
    end else if (start) begin
      phase <= 1'b0;
    end else if (step && mode == MODE_DELTA) begin
      phase <= pulse_separated_mode ? ~phase : 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rise and fall registers: compare values, or capture results.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rise_value <= CNT_RESET;
    end else if (rise_write) begin
      rise_value <= write_data;
    end else if (mode == MODE_CAPTURE && state == ST_RUN
                 && cap_level && !cap_prev) begin
      rise_value <= count;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fall_value <= CNT_RESET;
    end else if (fall_write) begin
      fall_value <= write_data;
    end else if (mode == MODE_CAPTURE && state == ST_RUN
                 && !cap_level && cap_prev) begin
      fall_value <= count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pseudo-random source: an LFSR stretched to all 2^16 states and restarted
  // with the counter, so one conversion visits every value exactly once. The
  // key moves on at each wrap, so the same level gives a new pattern next time.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lfsr <= LFSR_SEED;
      key  <= CNT_RESET;
    end else if (start) begin
      lfsr <= LFSR_SEED;
    end else if (step && mode == MODE_DELTA && (phase || !pulse_separated_mode)) begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]
               ^ (lfsr[14:0] == 15'h0000)};
      if (&count) begin
        key <= key + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output waveform.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_level <= 1'b0;
    end else if (mode == MODE_DELTA) begin
      if (state != ST_RUN || (pulse_separated_mode && !phase)) begin
        out_level <= 1'b0;
      end else begin
        // Comparing a permutation of the count against the level yields
        // exactly that many high slots per 2^16 slots.
        out_level <= ((lfsr ^ key) < rise_value);
      end
    end else if (mode == MODE_PWM) begin
      if (state == ST_DONE || state == ST_IDLE) begin
        out_level <= 1'b0;
      end else if (fall_hit) begin
        out_level <= 1'b0;
      end else if (rise_hit) begin
        out_level <= 1'b1;
      end
    end else begin
      out_level <= 1'b0;
    end
  end

  // Output enable only gates the pin; the unit keeps running internally.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timer_output    <= 1'b0;
      timer_output_oe <= 1'b0;
    end else begin
      timer_output    <= out_level;
      timer_output_oe <= output_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Match interrupt: a one-cycle pulse per enabled match, two cycles in pulse-separated delta mode where the count holds.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (rise_hit && rise_irq_enable) || (fall_hit && fall_irq_enable);
    end
  end
endmodule
`default_nettype wire

//--- tb/pin_model.sv
// Far-side pin model shared by both timer units: the gate/event and capture pins.
// Assumes the bench requests levels; pins change only on clock edges.
`timescale 1ns/1ps
`default_nettype none
module pin_model (
  // Clock
  input  wire logic clk,
  // Requested levels
  input  wire logic gate_req,
  input  wire logic cap_req,
  // Pins
  output var logic  clock_gate_input,
  output var logic  capture_input
);
  // The bench keeps edges eight clocks apart, well over the minimum width.
  always_ff @(posedge clk) begin
    clock_gate_input <= gate_req;
    capture_input    <= cap_req;
  end
endmodule
`default_nettype wire

//--- tb/timer_unit_monitor.sv
// Port checker bound to every timer unit.
// Assumes control inputs stay steady while a unit runs.
`timescale 1ns/1ps
`default_nettype none
module timer_unit_monitor
  import timer_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // Control
  input  wire logic                  start,
  input  wire logic                  stop,
  input  wire logic [2:0]            mode,
  input  wire logic                  single_shot,
  input  wire logic                  gate_enable,
  input  wire logic                  pulse_separated_mode,
  input  wire logic [PRESCALE_W-1:0] prescale,
  input  wire logic                  rise_irq_enable,
  input  wire logic                  fall_irq_enable,
  input  wire logic                  capture_read,
  // Pins and status
  input  wire logic                  clock_gate_input,
  input  wire logic                  timer_output,
  input  wire logic [CNT_W-1:0]      count,
  input  wire logic [CNT_W-1:0]      rise_value,
  input  wire logic [CNT_W-1:0]      fall_value,
  input  wire logic                  running,
  input  wire logic                  irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////
  // The stop guard skips the cycle where running still lags a stop.
  sequence pwm_run;
    mode == MODE_PWM && running && prescale == 5'h00 && rise_value != fall_value
      && !stop && !$past(stop);
  endsequence
  chk_pwm_rise: assert property (pwm_run ##0 count == rise_value |-> ##2 timer_output)
    else $error("pwm output missed rise");
  chk_pwm_fall: assert property (pwm_run ##0 count == fall_value |-> ##2 !timer_output)
    else $error("pwm output missed fall");
  chk_single_stop: assert property (pwm_run ##0 single_shot && count == fall_value
    |-> ##[1:3] !running)
    else $error("single shot kept running");
  chk_gate_freeze: assert property ((gate_enable && clock_gate_input && !start
    && mode == MODE_TIMER)[*8] |=> $stable(count))
    else $error("count moved while gated");
  chk_capture_read: assert property (mode == MODE_CAPTURE && running && capture_read
    |-> ##[1:3] !running)
    else $error("capture read did not stop");
  chk_timer_irq: assert property (mode == MODE_TIMER && running && fall_irq_enable
    && !gate_enable && !stop && prescale == 5'h00 && count == fall_value
    && count != $past(count) |-> ##[1:2] irq)
    else $error("timer match gave no irq");
  chk_irq_enabled: assert property (irq |-> $past(rise_irq_enable || fall_irq_enable))
    else $error("irq without enable");
  chk_rtz_gap: assert property (mode == MODE_DELTA && pulse_separated_mode && timer_output
    |=> !timer_output)
    else $error("adjacent pulses in separated mode");
endmodule
bind timer_unit timer_unit_monitor u_mon (.*);
`default_nettype wire

//--- tb/timer_unit_tb.sv
// Self-checking bench for two timer units with a pin model at their far side.
// Assumes the 25 MHz clock and the mode codes of timer_pkg.
`timescale 1ns/1ps
`default_nettype none
module timer_unit_tb;
  import timer_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, start = 1'b0, stop = 1'b0, single_shot = 1'b0;
  logic gate_enable = 1'b0, pulse_separated_mode = 1'b0, rise_irq_enable = 1'b0;
  logic fall_irq_enable = 1'b1, output_enable = 1'b0, capture_read = 1'b0;
  logic rise_write = 1'b0, fall_write = 1'b0, gate_req = 1'b0, cap_req = 1'b0, last;
  logic clock_gate_input, capture_input, timer_output, timer_output_oe, running, irq;
  logic pair_start = 1'b0, running2;
  logic [CNT_W-1:0]      count2;
  logic [2:0]            mode = 3'h0;
  logic [1:0]            edge_select = 2'h0;
  logic [PRESCALE_W-1:0] prescale = 5'h00;
  logic [CNT_W-1:0]      write_data = 16'h0000, count, rise_value, fall_value;
  int                    errors = 0, check_count = 0, cyc = 0, a, n, adj;
  always #20 clk = ~clk;
  timer_unit u_dut (.clk, .resetn, .start, .stop, .mode, .single_shot, .gate_enable,
    .edge_select, .pulse_separated_mode, .prescale, .rise_irq_enable, .fall_irq_enable,
    .output_enable, .capture_read, .rise_write, .fall_write, .write_data,
    .clock_gate_input, .capture_input, .timer_output, .timer_output_oe, .count,
    .rise_value, .fall_value, .running, .irq);
  pin_model u_pins (.clk, .gate_req, .cap_req, .clock_gate_input, .capture_input);
  // Second unit on its own start: it must stay at reset while u_dut runs.
  timer_unit u_pair (.clk, .resetn, .start(pair_start), .stop, .mode, .single_shot,
    .gate_enable, .edge_select, .pulse_separated_mode, .prescale, .rise_irq_enable,
    .fall_irq_enable, .output_enable, .capture_read, .rise_write, .fall_write,
    .write_data, .clock_gate_input, .capture_input, .timer_output(), .timer_output_oe(),
    .count(count2), .rise_value(), .fall_value(), .running(running2), .irq());
  ////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cfg(input logic [2:0] m, input logic ss, input logic [15:0] r, f);
    @(posedge clk);
    stop <= 1'b1;
    mode <= m;
    single_shot <= ss;
    rise_write <= 1'b1;
    write_data <= r;
    @(posedge clk);
    stop <= 1'b0;
    rise_write <= 1'b0;
    fall_write <= 1'b1;
    write_data <= f;
    @(posedge clk);
    fall_write <= 1'b0;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask
  task automatic idle(input int k);
    repeat (k) @(negedge clk);
  endtask
  // Counts high output cycles and high cycles that follow a high cycle.
  task automatic hi(input int k);
    n = 0;
    adj = 0;
    last = 1'b0;
    repeat (k) begin
      @(negedge clk);
      if (timer_output === 1'b1) begin
        n++;
        if (last) adj++;
      end
      last = (timer_output === 1'b1);
    end
  endtask
  task automatic wait_irq;
    a = 0;
    do begin
      @(negedge clk);
      a++;
    end while (irq !== 1'b1 && a < 500);
    check({15'h0000, irq}, 16'h0001);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    idle(1);
    check({count[11:0], timer_output, timer_output_oe, running, irq}, 16'h0000);
    for (int p = 0; p < 3; p++) begin
      @(posedge clk);
      prescale <= 5'(p);
      cfg(MODE_TIMER, 1'b0, 16'h0000, 16'h0005);
      wait_irq();
      n = cyc;
      wait_irq();
      check(16'(cyc - n), 16'(6 << p));
    end
    @(posedge clk);
    gate_enable <= 1'b1;
    gate_req <= 1'b1;
    idle(12);
    n = count;
    idle(8);
    check(count, 16'(n));
    @(posedge clk);
    gate_enable <= 1'b0;
    gate_req <= 1'b0;
    idle(10);
    check({15'h0000, count != 16'(n)}, 16'h0001);
    $display("test timer and gate done");
    @(posedge clk);
    prescale <= 5'h00;
    output_enable <= 1'b1;
    rise_irq_enable <= 1'b1;
    fall_irq_enable <= 1'b0;
    cfg(MODE_PWM, 1'b0, 16'h0002, 16'h0004);
    idle(10);
    hi(50);
    check(16'(n), 16'h0014);
    check({15'h0000, timer_output_oe}, 16'h0001);
    // Only the rise match may interrupt: the count has just passed 2.
    wait_irq();
    check(count, 16'h0003);
    cfg(MODE_PWM, 1'b1, 16'h0002, 16'h0004);
    hi(30);
    check(16'(n), 16'h0002);
    check({15'h0000, running | timer_output}, 16'h0000);
    $display("test pwm done");
    for (int e = 1; e < 4; e++) begin
      @(posedge clk);
      edge_select <= 2'(e);
      cfg(MODE_COUNTER, 1'b0, 16'h0000, 16'hFFFF);
      repeat (6) begin
        repeat (8) @(posedge clk);
        gate_req <= ~gate_req;
      end
      idle(10);
      check(count, (e == 3) ? 16'h0006 : 16'h0003);
    end
    $display("test event count done");
    cfg(MODE_CAPTURE, 1'b0, 16'h0000, 16'h0000);
    idle(10);
    @(posedge clk);
    cap_req <= 1'b1;
    repeat (30) @(posedge clk);
    cap_req <= 1'b0;
    idle(10);
    @(posedge clk);
    capture_read <= 1'b1;
    @(posedge clk);
    capture_read <= 1'b0;
    idle(5);
    check(fall_value - rise_value, 16'h001E);
    check({15'h0000, running}, 16'h0000);
    $display("test capture done");
    for (int s = 1; s >= 0; s--) begin
      @(posedge clk);
      pulse_separated_mode <= s[0];
      cfg(MODE_DELTA, 1'b0, 16'hF000, 16'h0000);
      hi(300);
      check({15'h0000, n > 0}, 16'h0001);
      check({15'h0000, adj == 0}, {15'h0000, s[0]});
    end
    // One whole NRZ conversion, aligned to start: exactly the level's high cycles.
    cfg(MODE_DELTA, 1'b0, 16'h0010, 16'h0000);
    idle(2);
    hi(65536);
    check(16'(n), 16'h0010);
    $display("test delta-sigma done");
    check(count2, 16'h0000);
    @(posedge clk);
    pair_start <= 1'b1;
    @(posedge clk);
    pair_start <= 1'b0;
    idle(3);
    check({15'h0000, running2}, 16'h0001);
    $display("test unit pair done");
    conclude();
  end
endmodule
`default_nettype wire
